// *** core/fws_poller.v ***
// Host controller that drives a parallel flash and polls its status bits.
// Assumes an AXI4-Lite master in software's place and the flash pins below.
`include "fws_regs.vh"
module fws_poller (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Flash pins
    output wire [17:0] flash_addr,
    output wire flash_ce_n,
    output wire flash_oe_n,
    output wire flash_we_n,
    input wire [7:0] flash_dq_i,
    output wire [7:0] flash_dq_o,
    output wire flash_dq_oe
);
    localparam [3:0] S_IDLE = 4'd0;
    localparam [3:0] S_ONE = 4'd1;
    localparam [3:0] S_FIRST = 4'd2;
    localparam [3:0] S_SECOND = 4'd3;
    localparam [3:0] S_RECHECK = 4'd4;
    localparam [3:0] S_RESET = 4'd5;
    localparam [3:0] S_PRE = 4'd6;
    localparam [3:0] S_ADD = 4'd7;
    localparam [3:0] S_POST = 4'd8;
    localparam [3:0] S_FINISH = 4'd9;

    // Software registers and sequencer state
    reg [2:0] cmd_q;
    reg [17:0] addr_q;
    reg [7:0] data_q;
    reg busy_q;
    reg [2:0] result_q;
    reg erasing_q;
    reg suspended_q;
    reg [7:0] last_q;
    reg [7:0] first_q;
    reg [3:0] st_q;
    reg go_q;
    reg start_q;
    reg is_wr_q;
    reg [17:0] cyc_addr_q;
    reg [7:0] cyc_data_q;
    wire cyc_done;
    wire [7:0] cyc_rdata;

    // Write channel: both taken in the same edge, response follows
    wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_take;
    assign s_axi_wready = wr_take;
    wire rd_take = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_arready = rd_take;
    wire wr_ok = (s_axi_awaddr == `FWS_OFF_CTRL) || (s_axi_awaddr == `FWS_OFF_ADDR) ||
        (s_axi_awaddr == `FWS_OFF_DATA);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h00000000;
            addr_q <= 18'h00000;
            data_q <= 8'h00;
            cmd_q <= `FWS_CMD_NONE;
            go_q <= 1'b0;
        end else begin
            go_q <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_take) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
                if (s_axi_awaddr == `FWS_OFF_ADDR && s_axi_wstrb != 4'h0) begin
                    addr_q <= s_axi_wdata[17:0];
                end
                if (s_axi_awaddr == `FWS_OFF_DATA && s_axi_wstrb[0]) begin
                    data_q <= s_axi_wdata[7:0];
                end
                // A command while busy is dropped; software watches the busy bit
                if (s_axi_awaddr == `FWS_OFF_CTRL && s_axi_wstrb[0] && !busy_q) begin
                    cmd_q <= s_axi_wdata[2:0];
                    go_q <= 1'b1;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr)
                    `FWS_OFF_CTRL: s_axi_rdata <= {29'h0, cmd_q};
                    `FWS_OFF_ADDR: s_axi_rdata <= {14'h0, addr_q};
                    `FWS_OFF_DATA: s_axi_rdata <= {24'h0, data_q};
                    `FWS_OFF_STAT: s_axi_rdata <= {26'h0, suspended_q, erasing_q, result_q, 1'b0} |
                        {31'h0, busy_q};
                    `FWS_OFF_RDAT: s_axi_rdata <= {24'h0, last_q};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end
        end
    end

    // Toggle tests between two consecutive reads
    wire busy_tgl = first_q[`FWS_BIT_BUSY_TGL] ^ cyc_rdata[`FWS_BIT_BUSY_TGL];
    wire sect_tgl = first_q[`FWS_BIT_SECT_TGL] ^ cyc_rdata[`FWS_BIT_SECT_TGL];

    always @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= S_IDLE;
            busy_q <= 1'b0;
            result_q <= `FWS_RES_DONE;
            erasing_q <= 1'b0;
            suspended_q <= 1'b0;
            last_q <= 8'h00;
            first_q <= 8'h00;
            start_q <= 1'b0;
            is_wr_q <= 1'b0;
            cyc_addr_q <= 18'h00000;
            cyc_data_q <= 8'h00;
        end else begin
            start_q <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (go_q) begin
                        busy_q <= 1'b1;
                        result_q <= `FWS_RES_BUSY;
                        start_q <= 1'b1;
                        cyc_addr_q <= addr_q;
                        cyc_data_q <= data_q;
                        case (cmd_q)
                            `FWS_CMD_READ: begin
                                is_wr_q <= 1'b0;
                                st_q <= S_ONE;
                            end
                            `FWS_CMD_WRITE: begin
                                is_wr_q <= 1'b1;
                                st_q <= S_ONE;
                            end
                            `FWS_CMD_POLL: begin
                                // Every poll request starts from the first read
                                is_wr_q <= 1'b0;
                                st_q <= S_FIRST;
                            end
                            `FWS_CMD_SERASE: begin
                                is_wr_q <= 1'b0;
                                st_q <= S_PRE;
                            end
                            `FWS_CMD_RESET: begin
                                is_wr_q <= 1'b1;
                                cyc_data_q <= `FWS_CMD_RESET_DATA;
                                st_q <= S_RESET;
                            end
                            default: begin
                                start_q <= 1'b0;
                                busy_q <= 1'b0;
                                result_q <= `FWS_RES_DONE;
                            end
                        endcase
                    end
                end
                S_ONE, S_RESET: begin
                    if (cyc_done) begin
                        if (!is_wr_q) begin
                            last_q <= cyc_rdata;
                        end
                        st_q <= S_FINISH;
                        result_q <= `FWS_RES_DONE;
                    end
                end
                S_FIRST: begin
                    if (cyc_done) begin
                        first_q <= cyc_rdata;
                        start_q <= 1'b1;
                        st_q <= S_SECOND;
                    end
                end
                S_SECOND, S_RECHECK: begin
                    if (cyc_done) begin
                        last_q <= cyc_rdata;
                        // Busy toggle says running; sector toggle marks erasing sectors
                        erasing_q <= busy_tgl && sect_tgl;
                        suspended_q <= !busy_tgl && sect_tgl && cyc_rdata[`FWS_BIT_POLL];
                        if (!busy_tgl) begin
                            // Busy toggle stopped: reported done; suspended needs sector toggle and poll bit high
                            result_q <= `FWS_RES_DONE;
                            st_q <= S_FINISH;
                        end else if (cyc_rdata[`FWS_BIT_FAIL] && st_q == S_SECOND) begin
                            first_q <= cyc_rdata;
                            start_q <= 1'b1;
                            st_q <= S_RECHECK;
                        end else if (st_q == S_RECHECK) begin
                            // Device stays in status mode until reset
                            result_q <= `FWS_RES_FAIL;
                            st_q <= S_FINISH;
                        end else begin
                            result_q <= `FWS_RES_BUSY;
                            st_q <= S_FINISH;
                        end
                    end
                end
                S_PRE: begin
                    if (cyc_done) begin
                        last_q <= cyc_rdata;
                        // Window bit is always read; command spacing is never assumed
                        if (cyc_rdata[`FWS_BIT_WINDOW]) begin
                            // Window shut: the add would be ignored, so it is not sent
                            result_q <= `FWS_RES_CLOSED;
                            st_q <= S_FINISH;
                        end else begin
                            is_wr_q <= 1'b1;
                            cyc_data_q <= `FWS_CMD_SERASE_DATA;
                            start_q <= 1'b1;
                            st_q <= S_ADD;
                        end
                    end
                end
                S_ADD: begin
                    if (cyc_done) begin
                        is_wr_q <= 1'b0;
                        start_q <= 1'b1;
                        st_q <= S_POST;
                    end
                end
                S_POST: begin
                    if (cyc_done) begin
                        last_q <= cyc_rdata;
                        // Window or polling bit high after the add: it may have been refused
                        if (cyc_rdata[`FWS_BIT_WINDOW] || cyc_rdata[`FWS_BIT_POLL]) begin
                            result_q <= `FWS_RES_REJECTED;
                        end else begin
                            result_q <= `FWS_RES_ACCEPTED;
                        end
                        st_q <= S_FINISH;
                    end
                end
                S_FINISH: begin
                    busy_q <= 1'b0;
                    st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    fws_bus_cycle u_cycle (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(start_q),
        .is_write(is_wr_q),
        .addr(cyc_addr_q),
        .wdata(cyc_data_q),
        .done(cyc_done),
        .rdata_q(cyc_rdata),
        .flash_addr_q(flash_addr),
        .flash_ce_n_q(flash_ce_n),
        .flash_oe_n_q(flash_oe_n),
        .flash_we_n_q(flash_we_n),
        .flash_dq_i(flash_dq_i),
        .flash_dq_o_q(flash_dq_o),
        .flash_dq_oe_q(flash_dq_oe)
    );
endmodule

// *** core/fws_regs.vh ***
// Constants for the flash status poller: register offsets, fields, codes, timings.
// Assumes an AXI4-Lite slave with 32-bit words and a 100 MHz aclk.
`ifndef FWS_REGS_VH
`define FWS_REGS_VH

`define FWS_OFF_CTRL 8'h00
`define FWS_OFF_ADDR 8'h04
`define FWS_OFF_DATA 8'h08
`define FWS_OFF_STAT 8'h0C
`define FWS_OFF_RDAT 8'h10

`define FWS_CMD_NONE 3'h0
`define FWS_CMD_READ 3'h1
`define FWS_CMD_WRITE 3'h2
`define FWS_CMD_POLL 3'h3
`define FWS_CMD_SERASE 3'h4
`define FWS_CMD_RESET 3'h5

`define FWS_RES_BUSY 3'h0
`define FWS_RES_DONE 3'h1
`define FWS_RES_FAIL 3'h2
`define FWS_RES_ACCEPTED 3'h3
`define FWS_RES_REJECTED 3'h4
`define FWS_RES_CLOSED 3'h5

`define FWS_BIT_POLL 7
`define FWS_BIT_BUSY_TGL 6
`define FWS_BIT_FAIL 5
`define FWS_BIT_WINDOW 3
`define FWS_BIT_SECT_TGL 2

`define FWS_CMD_RESET_DATA 8'hF0
`define FWS_CMD_SERASE_DATA 8'h30

`define FWS_CLK_NS 10
`define FWS_T_CYCLE_NS 80
`define FWS_T_CYCLE_CYC ((`FWS_T_CYCLE_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_T_OEH_NS 10
`define FWS_T_OEH_CYC ((`FWS_T_OEH_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_T_SPACE_US 50
`define FWS_T_SPACE_CYC (`FWS_T_SPACE_US * 1000 / `FWS_CLK_NS)

`endif

// *** core/fws_bus_cycle.v ***
// One strobed read or write cycle on the flash's parallel pins.
// Assumes the flash pins are asynchronous; timings come from cycle counts.
`include "fws_regs.vh"
module fws_bus_cycle (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Request
    input wire start,
    input wire is_write,
    input wire [17:0] addr,
    input wire [7:0] wdata,
    output wire done,
    output reg [7:0] rdata_q,
    // Flash pins
    output reg [17:0] flash_addr_q,
    output reg flash_ce_n_q,
    output reg flash_oe_n_q,
    output reg flash_we_n_q,
    input wire [7:0] flash_dq_i,
    output reg [7:0] flash_dq_o_q,
    output reg flash_dq_oe_q
);
    localparam integer STROBE_N = `FWS_T_CYCLE_CYC;
    localparam integer HOLD_N = `FWS_T_OEH_CYC;
    localparam [7:0] STROBE = STROBE_N[7:0];
    localparam [7:0] HOLD = HOLD_N[7:0];
    localparam [1:0] S_IDLE = 2'd0;
    localparam [1:0] S_STROBE = 2'd1;
    localparam [1:0] S_HOLD = 2'd2;
    reg [1:0] st_q;
    reg [7:0] cnt_q;
    reg wr_q;
    assign done = (st_q == S_HOLD) && (cnt_q == 8'h00);
    always @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= S_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            rdata_q <= 8'h00;
            flash_addr_q <= 18'h00000;
            flash_ce_n_q <= 1'b1;
            flash_oe_n_q <= 1'b1;
            flash_we_n_q <= 1'b1;
            flash_dq_o_q <= 8'h00;
            flash_dq_oe_q <= 1'b0;
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (start) begin
                        st_q <= S_STROBE;
                        cnt_q <= STROBE;
                        wr_q <= is_write;
                        flash_addr_q <= addr;
                        flash_dq_o_q <= wdata;
                        flash_dq_oe_q <= is_write;
                        flash_ce_n_q <= 1'b0;
                        flash_oe_n_q <= is_write;
                        flash_we_n_q <= ~is_write;
                    end
                end
                S_STROBE: begin
                    if (cnt_q == 8'h00) begin
                        // Rising strobe ends each cycle, giving one toggle per read
                        if (!wr_q) begin
                            rdata_q <= flash_dq_i;
                        end
                        flash_ce_n_q <= 1'b1;
                        flash_oe_n_q <= 1'b1;
                        flash_we_n_q <= 1'b1;
                        st_q <= S_HOLD;
                        cnt_q <= HOLD;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                S_HOLD: begin
                    if (cnt_q == 8'h00) begin
                        flash_dq_oe_q <= 1'b0;
                        st_q <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule

// *** bench/fws_poller_sva.sv ***
// Checker for the poller's register bus and flash strobe timing.
// Assumes it is bound to fws_poller and sees only its ports.
module fws_poller_sva (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Register bus
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // Flash pins
    input wire [17:0] flash_addr,
    input wire flash_ce_n,
    input wire flash_oe_n,
    input wire flash_we_n,
    input wire flash_dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_write_answer:
        assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid) else $error("write answer late");
    chk_write_release:
        assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
    chk_read_answer:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    chk_read_release:
        assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
    chk_write_refused:
        assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write taken while answering");
    // No bus fight while the flash drives
    chk_no_fight:
        assert property (!flash_oe_n |-> flash_we_n && !flash_dq_oe) else $error("host drives during read");
    chk_read_length:
        assert property ($fell(flash_oe_n) |=> (!flash_oe_n)[*8] ##1 flash_oe_n) else $error("read strobe length");
    chk_addr_held:
        assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr)) else $error("address moved");
    chk_write_drives:
        assert property (!flash_we_n |-> flash_dq_oe && !flash_ce_n) else $error("write without data");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property ($rose(flash_we_n));
endmodule

// *** bench/fws_flash_model.sv ***
// Behavioural parallel flash: array, program, sector erase, status bits.
// Assumes strobes low for several host cycles; the flash has no clock.
module fws_flash_model #(
    parameter integer WIN_NS = 4000,
    parameter integer PROG_READS = 3,
    parameter integer ERASE_READS = 6
) (
    // Flash pins
    input wire [17:0] flash_addr,
    input wire flash_ce_n,
    input wire flash_oe_n,
    input wire flash_we_n,
    input wire [7:0] dq_in,
    output reg [7:0] dq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [7:0] mem [0:255];
    reg [31:0] sel_q = 32'h0;
    reg busy_q = 1'b0;
    reg erase_q = 1'b0;
    reg fail_q = 1'b0;
    reg tgl6_q = 1'b0;
    reg tgl2_q = 1'b0;
    reg rd_seen = 1'b0;
    reg wr_seen = 1'b0;
    reg [7:0] last_q = 8'h00;
    reg [7:0] pd_q = 8'h00;
    reg [17:0] pa_q = 18'h0;
    integer left = 0;
    integer i;
    time win_t = 0;
    initial for (i = 0; i < 256; i = i + 1) mem[i] = 8'hFF;
    // Released bus shows the inverse of the last byte, not a stale copy
    always @* begin
        if (!flash_ce_n && !flash_oe_n && busy_q)
            dq_out = {erase_q ? 1'b0 : ~pd_q[7], tgl6_q, fail_q, 1'b0,
                erase_q && ($time - win_t >= WIN_NS), erase_q && sel_q[flash_addr[17:13]] && tgl2_q, 2'b00};
        else if (!flash_ce_n && !flash_oe_n)
            dq_out = mem[flash_addr[7:0]];
        else
            dq_out = ~last_q;
    end
    // Captured while driven, so the strobe edge cannot race the released value
    always @(dq_out) if (!flash_ce_n && !flash_oe_n) last_q = dq_out;
    always @(negedge flash_oe_n) rd_seen = 1'b1;
    always @(posedge flash_oe_n) if (rd_seen) begin
        rd_seen = 1'b0;
        if (busy_q) begin
            tgl6_q = ~tgl6_q;
            tgl2_q = ~tgl2_q;
            if (!fail_q && (!erase_q || $time - win_t >= WIN_NS)) left = left - 1;
            // Failed operation never ends by itself
            if (!fail_q && left == 0) begin
                if (erase_q) for (i = 0; i < 256; i = i + 1) mem[i] = 8'hFF;
                else mem[pa_q[7:0]] = pd_q;
                busy_q = 1'b0;
                erase_q = 1'b0;
                sel_q = 32'h0;
            end
        end
    end
    always @(negedge flash_we_n) wr_seen = 1'b1;
    always @(posedge flash_we_n) if (wr_seen) begin
        wr_seen = 1'b0;
        if (dq_in == 8'hF0 && !(erase_q && $time - win_t >= WIN_NS)) begin
            busy_q = 1'b0;
            fail_q = 1'b0;
            erase_q = 1'b0;
            sel_q = 32'h0;
        end else if (dq_in == 8'h30 && (!busy_q || (erase_q && $time - win_t < WIN_NS))) begin
            busy_q = 1'b1;
            erase_q = 1'b1;
            sel_q[flash_addr[17:13]] = 1'b1;
            win_t = $time;
            left = ERASE_READS;
        end else if (!busy_q) begin
            busy_q = 1'b1;
            pa_q = flash_addr;
            pd_q = dq_in;
            left = PROG_READS;
            fail_q = |(dq_in & ~mem[flash_addr[7:0]]);
        end
    end
endmodule

// *** bench/test_fws_poller.sv ***
// Bench for the flash status poller: register tasks and flash scenarios.
// Assumes the behavioural flash model on the flash pins.
`include "fws_regs.vh"
module test_fws_poller;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [17:0] A = 18'h00020;
    localparam [17:0] B = 18'h04020;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [7:0] s_axi_awaddr = 8'h00;
    reg s_axi_awvalid = 1'b0;
    reg [31:0] s_axi_wdata = 32'h0;
    reg s_axi_wvalid = 1'b0;
    reg s_axi_bready = 1'b0;
    reg [7:0] s_axi_araddr = 8'h00;
    reg s_axi_arvalid = 1'b0;
    reg s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [17:0] flash_addr;
    wire flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
    wire [7:0] flash_dq_o, mdl_dq;
    wire [7:0] dq_bus = flash_dq_oe ? flash_dq_o : mdl_dq;
    integer fail_count = 0;
    integer checks_done = 0;
    reg [31:0] rd_q;
    reg [1:0] resp_q;
    reg [2:0] res_q;
    always #5 aclk = ~aclk;
    fws_poller uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_i(dq_bus),
        .flash_dq_o, .flash_dq_oe);
    fws_flash_model flash (.flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .dq_in(dq_bus), .dq_out(mdl_dq));
    task tally_and_finish;
        begin
            $display("Counts: %0d checks, %0d mismatches", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task check(input [63:0] what, input [31:0] exp, input [31:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // Every wait is bounded so a stuck handshake ends the run
    task guard(input integer n);
        if (n >= 1000) begin
            fail_count = fail_count + 1;
            $display("MISMATCH wait expected answer seen timeout");
            tally_and_finish;
        end
    endtask
    task axi_write(input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            for (n = 0; n < 1000 && !(s_axi_awready && s_axi_wready); n = n + 1) @(posedge aclk);
            guard(n);
            s_axi_awvalid <= 1'b0;
            s_axi_wvalid <= 1'b0;
            for (n = 0; n < 1000 && !s_axi_bvalid; n = n + 1) @(posedge aclk);
            guard(n);
            resp_q = s_axi_bresp;
            s_axi_bready <= 1'b0;
        end
    endtask
    task axi_read(input [7:0] a);
        integer n;
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            for (n = 0; n < 1000 && !s_axi_arready; n = n + 1) @(posedge aclk);
            guard(n);
            s_axi_arvalid <= 1'b0;
            for (n = 0; n < 1000 && !s_axi_rvalid; n = n + 1) @(posedge aclk);
            guard(n);
            rd_q = s_axi_rdata;
            resp_q = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask
    task op(input [2:0] cmd, input [17:0] a, input [7:0] d);
        integer n;
        begin
            axi_write(`FWS_OFF_ADDR, {14'h0, a});
            axi_write(`FWS_OFF_DATA, {24'h0, d});
            axi_write(`FWS_OFF_CTRL, {29'h0, cmd});
            rd_q = 32'h1;
            for (n = 0; n < 1000 && rd_q[0] !== 1'b0; n = n + 1) axi_read(`FWS_OFF_STAT);
            if (rd_q[0] !== 1'b0) guard(1000);
            res_q = rd_q[3:1];
        end
    endtask
    task poll_wait(input [17:0] a);
        integer k;
        begin
            res_q = `FWS_RES_BUSY;
            for (k = 0; k < 40 && res_q === `FWS_RES_BUSY; k = k + 1) op(`FWS_CMD_POLL, a, 8'h00);
            if (res_q === `FWS_RES_BUSY) guard(1000);
        end
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`FWS_OFF_STAT);
        check("stat", 32'h2, rd_q);
        axi_read(8'h14);
        check("rresp", 32'h2, {30'h0, resp_q});
        check("rdata", 32'h0, rd_q);
        axi_write(8'h14, 32'h0);
        check("bresp", 32'h2, {30'h0, resp_q});
        $display("test registers done");
        op(`FWS_CMD_WRITE, A, 8'h51);
        op(`FWS_CMD_POLL, A, 8'h00);
        check("poll1", `FWS_RES_BUSY, res_q);
        poll_wait(A);
        check("poll", `FWS_RES_DONE, res_q);
        op(`FWS_CMD_READ, A, 8'h00);
        axi_read(`FWS_OFF_RDAT);
        check("array", 32'h51, rd_q);
        $display("test program done");
        op(`FWS_CMD_WRITE, A, 8'hFF);
        poll_wait(A);
        check("fail", `FWS_RES_FAIL, res_q);
        op(`FWS_CMD_RESET, A, 8'h00);
        op(`FWS_CMD_READ, A, 8'h00);
        axi_read(`FWS_OFF_RDAT);
        check("recover", 32'h51, rd_q);
        op(`FWS_CMD_WRITE, A, 8'h00);
        op(`FWS_CMD_SERASE, A, 8'h00);
        check("reject", `FWS_RES_REJECTED, res_q);
        poll_wait(A);
        $display("test failure done");
        op(`FWS_CMD_SERASE, A, 8'h00);
        check("add1", `FWS_RES_ACCEPTED, res_q);
        repeat (250) @(posedge aclk);
        op(`FWS_CMD_SERASE, B, 8'h00);
        check("add2", `FWS_RES_ACCEPTED, res_q);
        repeat (250) @(posedge aclk);
        op(`FWS_CMD_SERASE, A, 8'h00);
        check("add3", `FWS_RES_ACCEPTED, res_q);
        repeat (500) @(posedge aclk);
        op(`FWS_CMD_SERASE, B, 8'h00);
        check("add4", `FWS_RES_CLOSED, res_q);
        op(`FWS_CMD_POLL, A, 8'h00);
        check("erasing", 32'h1, {31'h0, rd_q[4]});
        check("susp", 32'h0, {31'h0, rd_q[5]});
        poll_wait(A);
        check("erase", `FWS_RES_DONE, res_q);
        op(`FWS_CMD_READ, B, 8'h00);
        axi_read(`FWS_OFF_RDAT);
        check("erased", 32'hFF, rd_q);
        $display("test erase done");
        tally_and_finish;
    end
endmodule
bind fws_poller fws_poller_sva chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .flash_addr,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_oe);
